/* hw/ssrl_defs.vh */
`ifndef SSRL_DEFS_VH
`define SSRL_DEFS_VH
// Register word indices on the Avalon slave
`define SSRL_REG_CTRL 4'h0
`define SSRL_REG_MAG_LIM 4'h1
`define SSRL_REG_FREQ_LIM 4'h2
`define SSRL_REG_PHASE_LIM 4'h3
`define SSRL_REG_CLOSE_TIME 4'h4
`define SSRL_REG_RATIO 4'h5
`define SSRL_REG_ANGLE_CORR 4'h6
`define SSRL_REG_LIVE_LVL 4'h7
`define SSRL_REG_DEAD_LVL 4'h8
`define SSRL_REG_STATUS 4'h9
`define SSRL_REG_MEAS_MAG 4'ha
`define SSRL_REG_MEAS_ANG 4'hb
// Control register field positions
`define SSRL_CTRL_ENABLE 0
`define SSRL_CTRL_MODE 1
`define SSRL_CTRL_XFMR 2
`define SSRL_CTRL_LIVE_BUS_DEAD_LINE 3
`define SSRL_CTRL_DEAD_BUS_LIVE_LINE 4
`define SSRL_CTRL_DEAD_BUS_DEAD_LINE 5
`define SSRL_CTRL_REF_LO 6
`define SSRL_CTRL_REF_HI 7
// Reset values
`define SSRL_RST_CTRL 8'h00
`define SSRL_RST_MAG_LIM 16'h0064
`define SSRL_RST_FREQ_LIM 16'h00c8
`define SSRL_RST_PHASE_LIM 16'h0064
`define SSRL_RST_CLOSE_TIME 16'h0032
`define SSRL_RST_RATIO 16'h1000
`define SSRL_RST_ANGLE_CORR 16'h0000
`define SSRL_RST_LIVE_LVL 16'h0320
`define SSRL_RST_DEAD_LVL 16'h0190
// Angle scale, tenths of a degree
`define SSRL_ANG_FULL 18'h00e10
`define SSRL_ANG_HALF 18'h00708
// Ratio fraction bits, lead scale (0.0036 as 236 / 2^16)
`define SSRL_RATIO_SHIFT 12
`define SSRL_LEAD_MULT 9'h0ec
`define SSRL_LEAD_SHIFT 16
`endif

/* hw/ssrl_xfmr_comp.v */
`timescale 1ns/10ps
`include "ssrl_defs.vh"
module ssrl_xfmr_comp (
  input wire clk,
  input wire reset,
  input wire in_valid,
  input wire enable,
  input wire [15:0] mag,
  input wire [15:0] ang,
  input wire [15:0] ratio,
  input wire [15:0] corr,
  output reg out_valid_r,
  output reg [15:0] mag_r,
  output reg [15:0] ang_r
);
  // Amplitude scaled by line/bus ratio, saturated
  wire [31:0] prod = mag * ratio;
  wire [19:0] scaled = prod[31:`SSRL_RATIO_SHIFT];
  wire [15:0] mag_c = (|scaled[19:16]) ? 16'hffff : scaled[15:0];
  // Angle moved back by the correction, kept in one turn
  wire signed [17:0] a0 = $signed({2'b00, ang}) - $signed({{2{corr[15]}}, corr});
  wire signed [17:0] a1 = (a0 < 18'sh00000) ? a0 + $signed(`SSRL_ANG_FULL) :
                          (a0 >= $signed(`SSRL_ANG_FULL)) ? a0 - $signed(`SSRL_ANG_FULL) : a0;

  // Registered corrected line phasor
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      out_valid_r <= 1'b0;
      mag_r <= 16'h0000;
      ang_r <= 16'h0000;
    end else begin
      out_valid_r <= in_valid;
      if (in_valid) begin
        mag_r <= enable ? mag_c : mag;
        ang_r <= enable ? a1[15:0] : ang;
      end
    end
  end
endmodule

/* hw/ssrl_lead_angle.v */
`timescale 1ns/10ps
`include "ssrl_defs.vh"
module ssrl_lead_angle (
  input wire clk,
  input wire reset,
  input wire in_valid,
  input wire enable,
  input wire [16:0] freq_diff,
  input wire [15:0] close_time,
  output reg out_valid_r,
  output reg [17:0] advance_r
);
  // Angle travelled during closing: slip(mHz) * t(ms) * 0.0036 tenths of a degree
  wire signed [33:0] p1 = $signed(freq_diff) * $signed({1'b0, close_time});
  wire signed [43:0] p2 = p1 * $signed({1'b0, `SSRL_LEAD_MULT});
  wire signed [27:0] p3 = p2[43:`SSRL_LEAD_SHIFT];
  wire signed [27:0] half = $signed({10'h000, `SSRL_ANG_HALF});
  wire signed [27:0] sat = (p3 > half) ? half : (p3 < -half) ? -half : p3;

  // Registered advance, zero when no lead is wanted
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      out_valid_r <= 1'b0;
      advance_r <= 18'h00000;
    end else begin
      out_valid_r <= in_valid;
      if (in_valid) begin
        advance_r <= enable ? sat[17:0] : 18'h00000;
      end
    end
  end
endmodule

/* hw/ssrl_sync_release.v */
`timescale 1ns/10ps
`include "ssrl_defs.vh"
module ssrl_sync_release #(
  parameter AW = 4
) (
  input wire clk,
  input wire reset,
  input wire [AW-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire sample_valid,
  input wire [15:0] bus_phase_one_voltage,
  input wire [15:0] bus_phase_one_angle,
  input wire [15:0] bus_phase_two_voltage,
  input wire [15:0] bus_phase_two_angle,
  input wire [15:0] bus_phase_three_voltage,
  input wire [15:0] bus_phase_three_angle,
  input wire [15:0] bus_frequency,
  input wire [15:0] line_side_voltage,
  input wire [15:0] line_side_angle,
  input wire [15:0] line_frequency,
  input wire sync_bypass_in,
  output reg synchronous_systems_r,
  output reg close_release_r,
  output reg check_overridden_r
);
  reg [7:0] ctrl_r;
  reg [15:0] mag_lim_r;
  reg [15:0] freq_lim_r;
  reg [15:0] ph_lim_r;
  reg [15:0] close_t_r;
  reg [15:0] ratio_r;
  reg [15:0] corr_r;
  reg [15:0] live_lvl_r;
  reg [15:0] dead_lvl_r;
  reg [31:0] rdata_r;
  reg wait_r;
  reg [31:0] rd_nxt;
  reg byp_s1_r;
  reg byp_s2_r;
  reg [15:0] bus_mag_r;
  reg [15:0] bus_ang_r;
  reg [15:0] bfreq_r;
  reg [15:0] lfreq_r;
  reg bus_live_r;
  reg bus_dead_r;
  reg line_live_r;
  reg line_dead_r;
  reg v1_r;
  reg [15:0] magd_r;
  reg [16:0] fd_r;
  reg [17:0] ad_r;
  reg [15:0] magd2_r;
  reg [16:0] fabs2_r;
  reg [17:0] ad2_r;
  reg mag_ok_r;
  reg freq_ok_r;
  reg ph_ok_r;
  reg [17:0] pa_r;
  reg [15:0] sel_mag;
  reg [15:0] sel_ang;
  wire xv;
  wire [15:0] lmag_c;
  wire [15:0] lang_c;
  wire lv;
  wire [17:0] adv;
  wire [17:0] pa_nxt;
  wire ovr_nxt;

  // Byte-lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // Unsigned magnitude difference
  function [15:0] absdiff;
    input [15:0] a;
    input [15:0] b;
    begin
      absdiff = (a >= b) ? a - b : b - a;
    end
  endfunction

  // Magnitude of a signed value
  function [16:0] abs18;
    input [17:0] v;
    reg [17:0] t;
    begin
      t = v[17] ? (~v + 18'h00001) : v;
      abs18 = t[16:0];
    end
  endfunction

  // Signed angle folded into one half-turn each way
  function [17:0] wrap_ang;
    input [17:0] a;
    begin
      if ($signed(a) >= $signed(`SSRL_ANG_HALF))
        wrap_ang = a - `SSRL_ANG_FULL;
      else if ($signed(a) < -$signed(`SSRL_ANG_HALF))
        wrap_ang = a + `SSRL_ANG_FULL;
      else
        wrap_ang = a;
    end
  endfunction

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

  // Read multiplexer, unmapped words read zero
  always @* begin
    rd_nxt = 32'h00000000;
    if (avs_address == `SSRL_REG_CTRL)
      rd_nxt = {24'h000000, ctrl_r};
    else if (avs_address == `SSRL_REG_MAG_LIM)
      rd_nxt = {16'h0000, mag_lim_r};
    else if (avs_address == `SSRL_REG_FREQ_LIM)
      rd_nxt = {16'h0000, freq_lim_r};
    else if (avs_address == `SSRL_REG_PHASE_LIM)
      rd_nxt = {16'h0000, ph_lim_r};
    else if (avs_address == `SSRL_REG_CLOSE_TIME)
      rd_nxt = {16'h0000, close_t_r};
    else if (avs_address == `SSRL_REG_RATIO)
      rd_nxt = {16'h0000, ratio_r};
    else if (avs_address == `SSRL_REG_ANGLE_CORR)
      rd_nxt = {16'h0000, corr_r};
    else if (avs_address == `SSRL_REG_LIVE_LVL)
      rd_nxt = {16'h0000, live_lvl_r};
    else if (avs_address == `SSRL_REG_DEAD_LVL)
      rd_nxt = {16'h0000, dead_lvl_r};
    else if (avs_address == `SSRL_REG_STATUS)
      rd_nxt = {22'h000000, byp_s2_r, line_dead_r, line_live_r, bus_dead_r, bus_live_r,
                ph_ok_r, freq_ok_r, mag_ok_r, close_release_r, synchronous_systems_r};
    else if (avs_address == `SSRL_REG_MEAS_MAG)
      rd_nxt = {16'h0000, magd_r};
    else if (avs_address == `SSRL_REG_MEAS_ANG)
      rd_nxt = {{14{pa_r[17]}}, pa_r};
  end

  // Avalon slave: one wait cycle, write lands when waitrequest is low
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
      ctrl_r <= `SSRL_RST_CTRL;
      mag_lim_r <= `SSRL_RST_MAG_LIM;
      freq_lim_r <= `SSRL_RST_FREQ_LIM;
      ph_lim_r <= `SSRL_RST_PHASE_LIM;
      close_t_r <= `SSRL_RST_CLOSE_TIME;
      ratio_r <= `SSRL_RST_RATIO;
      corr_r <= `SSRL_RST_ANGLE_CORR;
      live_lvl_r <= `SSRL_RST_LIVE_LVL;
      dead_lvl_r <= `SSRL_RST_DEAD_LVL;
    end else if ((avs_read || avs_write) && wait_r) begin
      wait_r <= 1'b0;
      // Only a read reloads the data word, so it holds across writes
      if (avs_read)
        rdata_r <= rd_nxt;
    end else if (!wait_r) begin
      wait_r <= 1'b1;
      if (avs_write) begin
        if (avs_address == `SSRL_REG_CTRL && avs_byteenable[0])
          ctrl_r <= avs_writedata[7:0];
        else if (avs_address == `SSRL_REG_MAG_LIM)
          mag_lim_r <= merge16(mag_lim_r, avs_writedata, avs_byteenable);
        else if (avs_address == `SSRL_REG_FREQ_LIM)
          freq_lim_r <= merge16(freq_lim_r, avs_writedata, avs_byteenable);
        else if (avs_address == `SSRL_REG_PHASE_LIM)
          ph_lim_r <= merge16(ph_lim_r, avs_writedata, avs_byteenable);
        else if (avs_address == `SSRL_REG_CLOSE_TIME)
          close_t_r <= merge16(close_t_r, avs_writedata, avs_byteenable);
        else if (avs_address == `SSRL_REG_RATIO)
          ratio_r <= merge16(ratio_r, avs_writedata, avs_byteenable);
        else if (avs_address == `SSRL_REG_ANGLE_CORR)
          corr_r <= merge16(corr_r, avs_writedata, avs_byteenable);
        else if (avs_address == `SSRL_REG_LIVE_LVL)
          live_lvl_r <= merge16(live_lvl_r, avs_writedata, avs_byteenable);
        else if (avs_address == `SSRL_REG_DEAD_LVL)
          dead_lvl_r <= merge16(dead_lvl_r, avs_writedata, avs_byteenable);
      end
    end
  end

  always @* begin
    case (ctrl_r[`SSRL_CTRL_REF_HI:`SSRL_CTRL_REF_LO])
      2'h1: begin
        sel_mag = bus_phase_two_voltage;
        sel_ang = bus_phase_two_angle;
      end
      2'h2: begin
        sel_mag = bus_phase_three_voltage;
        sel_ang = bus_phase_three_angle;
      end
      default: begin
        sel_mag = bus_phase_one_voltage;
        sel_ang = bus_phase_one_angle;
      end
    endcase
  end

  // Bypass pin synchroniser
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      byp_s1_r <= 1'b0;
      byp_s2_r <= 1'b0;
    end else begin
      byp_s1_r <= sync_bypass_in;
      byp_s2_r <= byp_s1_r;
    end
  end

  // Stage 0: bus sample and live/dead levels
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_mag_r <= 16'h0000;
      bus_ang_r <= 16'h0000;
      bfreq_r <= 16'h0000;
      lfreq_r <= 16'h0000;
      bus_live_r <= 1'b0;
      bus_dead_r <= 1'b0;
      line_live_r <= 1'b0;
      line_dead_r <= 1'b0;
    end else if (sample_valid) begin
      bus_mag_r <= sel_mag;
      bus_ang_r <= sel_ang;
      bfreq_r <= bus_frequency;
      lfreq_r <= line_frequency;
      bus_live_r <= sel_mag >= live_lvl_r;
      bus_dead_r <= sel_mag < dead_lvl_r;
      line_live_r <= line_side_voltage >= live_lvl_r;
      line_dead_r <= line_side_voltage < dead_lvl_r;
    end
  end

  // line corrected by ratio and angle
  ssrl_xfmr_comp u_xfmr (
    .clk(clk),
    .reset(reset),
    .in_valid(sample_valid),
    .enable(ctrl_r[`SSRL_CTRL_XFMR]),
    .mag(line_side_voltage),
    .ang(line_side_angle),
    .ratio(ratio_r),
    .corr(corr_r),
    .out_valid_r(xv),
    .mag_r(lmag_c),
    .ang_r(lang_c)
  );

  // Stage 1: raw differences
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      v1_r <= 1'b0;
      magd_r <= 16'h0000;
      fd_r <= 17'h00000;
      ad_r <= 18'h00000;
    end else begin
      v1_r <= xv;
      if (xv) begin
        magd_r <= absdiff(bus_mag_r, lmag_c);
        fd_r <= {1'b0, bfreq_r} - {1'b0, lfreq_r};
        ad_r <= wrap_ang({2'b00, bus_ang_r} - {2'b00, lang_c});
      end
    end
  end

  ssrl_lead_angle u_lead (
    .clk(clk),
    .reset(reset),
    .in_valid(v1_r),
    .enable(ctrl_r[`SSRL_CTRL_MODE]),
    .freq_diff(fd_r),
    .close_time(close_t_r),
    .out_valid_r(lv),
    .advance_r(adv)
  );

  // Stage 2: differences held beside the lead
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      magd2_r <= 16'h0000;
      fabs2_r <= 17'h00000;
      ad2_r <= 18'h00000;
    end else if (v1_r) begin
      magd2_r <= magd_r;
      fabs2_r <= abs18({fd_r[16], fd_r});
      ad2_r <= ad_r;
    end
  end

  assign pa_nxt = wrap_ang(ad2_r + adv);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mag_ok_r <= 1'b0;
      freq_ok_r <= 1'b0;
      ph_ok_r <= 1'b0;
      pa_r <= 18'h00000;
      synchronous_systems_r <= 1'b0;
    end else if (lv) begin
      mag_ok_r <= magd2_r <= mag_lim_r;
      freq_ok_r <= fabs2_r <= {1'b0, freq_lim_r};
      ph_ok_r <= abs18(pa_nxt) <= {1'b0, ph_lim_r};
      pa_r <= pa_nxt;
      synchronous_systems_r <= (magd2_r <= mag_lim_r) && (fabs2_r <= {1'b0, freq_lim_r}) &&
                               (abs18(pa_nxt) <= {1'b0, ph_lim_r});
    end
  end

  assign ovr_nxt = (ctrl_r[`SSRL_CTRL_LIVE_BUS_DEAD_LINE] && bus_live_r && line_dead_r) ||
                   (ctrl_r[`SSRL_CTRL_DEAD_BUS_LIVE_LINE] && bus_dead_r && line_live_r) ||
                   (ctrl_r[`SSRL_CTRL_DEAD_BUS_DEAD_LINE] && bus_dead_r && line_dead_r);

  // release from sync, override or bypass
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      close_release_r <= 1'b0;
      check_overridden_r <= 1'b0;
    end else begin
      check_overridden_r <= ovr_nxt;
      close_release_r <= ctrl_r[`SSRL_CTRL_ENABLE] && (synchronous_systems_r || ovr_nxt || byp_s2_r);
    end
  end
endmodule

/* verification/ssrl_front_end.sv */
`timescale 1ns/10ps
module ssrl_front_end (
  input wire clk,
  input wire fire,
  input wire [15:0] bm,
  input wire [15:0] ba,
  input wire [15:0] lm,
  input wire [15:0] la,
  input wire [15:0] bf,
  input wire [15:0] lf,
  output logic sample_valid = 1'b0,
  output logic [15:0] bus_phase_one_voltage = 16'h0000,
  output logic [15:0] bus_phase_one_angle = 16'h0000,
  output logic [15:0] bus_phase_two_voltage = 16'h0000,
  output logic [15:0] bus_phase_two_angle = 16'h0000,
  output logic [15:0] bus_phase_three_voltage = 16'h0000,
  output logic [15:0] bus_phase_three_angle = 16'h0000,
  output logic [15:0] bus_frequency = 16'h0000,
  output logic [15:0] line_side_voltage = 16'h0000,
  output logic [15:0] line_side_angle = 16'h0000,
  output logic [15:0] line_frequency = 16'h0000
);
  always @(posedge clk) begin
    sample_valid <= fire;
    if (fire) begin
      bus_phase_one_voltage <= bm;
      bus_phase_one_angle <= ba;
      bus_phase_two_voltage <= ~bm; // Unused phases differ
      bus_phase_two_angle <= ~ba;
      bus_phase_three_voltage <= bm ^ 16'h5a5a;
      bus_phase_three_angle <= ba ^ 16'h0a5a;
      bus_frequency <= bf;
      line_side_voltage <= lm;
      line_side_angle <= la;
      line_frequency <= lf;
    end
  end
endmodule

/* verification/ssrl_check_monitor.sv */
`timescale 1ns/10ps
module ssrl_check_monitor (
  input wire clk,
  input wire reset,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire sample_valid,
  input wire sync_bypass_in,
  input wire synchronous_systems_r,
  input wire close_release_r,
  input wire check_overridden_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Request taken, answered for one cycle
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  bus_answer_a: assert property (s_taken |=> s_answer)
    else $error("bus answer missing");
  idle_wait_a: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("wait dropped with no request");
  upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  data_hold_a: assert property (!$past(avs_read && avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data moved");
  sync_timing_a: assert property ($changed(synchronous_systems_r) |-> $past(sample_valid, 4))
    else $error("sync changed off sample");
  ovr_timing_a: assert property ($changed(check_overridden_r) |-> $past(sample_valid, 2) ||
    $past(avs_write && !avs_waitrequest, 2))
    else $error("override changed off sample");
  release_cause_a: assert property (close_release_r |-> $past(synchronous_systems_r) ||
    check_overridden_r || $past(sync_bypass_in, 3))
    else $error("release without cause");
endmodule
bind ssrl_sync_release ssrl_check_monitor ssrl_check_monitor_inst (
  .clk(clk), .reset(reset), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid),
  .sync_bypass_in(sync_bypass_in), .synchronous_systems_r(synchronous_systems_r),
  .close_release_r(close_release_r), .check_overridden_r(check_overridden_r));

/* verification/testbench.sv */
`timescale 1ns/10ps
`include "ssrl_defs.vh"
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  logic sync_bypass_in = 1'b0;
  logic fire = 1'b0;
  logic [15:0] bm = 16'h0, ba = 16'h0, lm = 16'h0, la = 16'h0, bf = 16'h0, lf = 16'h0;
  wire sample_valid;
  wire [15:0] p1v, p1a, p2v, p2a, p3v, p3a, bfo, lvo, lao, lfo;
  wire sys_sync, sys_release, sys_ovr;
  int err_count = 0;
  int checks = 0;
  logic [31:0] rd;
  // Clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  ssrl_front_end ssrl_front_end_inst (.clk(clk), .fire(fire), .bm(bm), .ba(ba), .lm(lm), .la(la),
    .bf(bf), .lf(lf), .sample_valid(sample_valid), .bus_phase_one_voltage(p1v),
    .bus_phase_one_angle(p1a), .bus_phase_two_voltage(p2v), .bus_phase_two_angle(p2a),
    .bus_phase_three_voltage(p3v), .bus_phase_three_angle(p3a), .bus_frequency(bfo),
    .line_side_voltage(lvo), .line_side_angle(lao), .line_frequency(lfo));
  ssrl_sync_release ssrl_sync_release_inst (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid),
    .bus_phase_one_voltage(p1v), .bus_phase_one_angle(p1a), .bus_phase_two_voltage(p2v),
    .bus_phase_two_angle(p2a), .bus_phase_three_voltage(p3v), .bus_phase_three_angle(p3a),
    .bus_frequency(bfo), .line_side_voltage(lvo), .line_side_angle(lao), .line_frequency(lfo),
    .sync_bypass_in(sync_bypass_in), .synchronous_systems_r(sys_sync),
    .close_release_r(sys_release), .check_overridden_r(sys_ovr));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks++;
      if (got !== exp) begin
        err_count++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Bus cycle held until wait is low
  task av(input bit wr, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
        @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task smp(input [15:0] b_m, input [15:0] b_a, input [15:0] l_m, input [15:0] l_a,
           input [15:0] b_f, input [15:0] l_f);
    begin
      @(posedge clk);
      bm <= b_m;
      ba <= b_a;
      lm <= l_m;
      la <= l_a;
      bf <= b_f;
      lf <= l_f;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
    end
  endtask
  task t_regs;
    begin
      av(0, 4'h0, 0); chk(rd, {24'h0, `SSRL_RST_CTRL});
      av(0, 4'h1, 0); chk(rd, {16'h0, `SSRL_RST_MAG_LIM});
      av(0, 4'h2, 0); chk(rd, {16'h0, `SSRL_RST_FREQ_LIM});
      av(0, 4'h3, 0); chk(rd, {16'h0, `SSRL_RST_PHASE_LIM});
      av(0, 4'h4, 0); chk(rd, {16'h0, `SSRL_RST_CLOSE_TIME});
      av(0, 4'h5, 0); chk(rd, {16'h0, `SSRL_RST_RATIO});
      av(0, 4'h8, 0); chk(rd, {16'h0, `SSRL_RST_DEAD_LVL});
      av(1, 4'hc, 32'h1234);
      av(0, 4'hc, 0); chk(rd, 32'h0);
      $display("test regs done");
    end
  endtask
  task t_limits;
    begin
      av(1, 4'h0, 32'h1);
      smp(16'h03e8, 16'h0000, 16'h044c, 16'h0000, 16'hc350, 16'hc350); chk(sys_sync, 32'h1);
      chk(sys_release, 32'h1);
      av(0, 4'h9, 0); chk(rd, 32'h000000bf);
      av(0, 4'ha, 0); chk(rd, 32'h00000064);
      smp(16'h03e8, 16'h0000, 16'h044d, 16'h0000, 16'hc350, 16'hc350); chk(sys_sync, 32'h0);
      chk(sys_release, 32'h0);
      smp(16'h03e8, 16'h0000, 16'h03e8, 16'h0000, 16'hc419, 16'hc350); chk(sys_sync, 32'h0);
      smp(16'h03e8, 16'h0000, 16'h03e8, 16'h0000, 16'hc418, 16'hc350); chk(sys_sync, 32'h1);
      smp(16'h03e8, 16'h0065, 16'h03e8, 16'h0000, 16'hc350, 16'hc350); chk(sys_sync, 32'h0);
      smp(16'h03e8, 16'h0dde, 16'h03e8, 16'h0032, 16'hc350, 16'hc350); chk(sys_sync, 32'h1);
      $display("test limits done");
    end
  endtask
  task t_lead;
    begin
      av(1, 4'h0, 32'h3);
      smp(16'h03e8, 16'h005a, 16'h03e8, 16'h0000, 16'hc3b4, 16'hc350); chk(sys_sync, 32'h0);
      av(1, 4'h0, 32'h1);
      smp(16'h03e8, 16'h005a, 16'h03e8, 16'h0000, 16'hc3b4, 16'hc350); chk(sys_sync, 32'h1);
      $display("test lead done");
    end
  endtask
  task t_ovr;
    begin
      for (int i = 0; i < 3; i++) begin
        av(1, 4'h0, 32'h1 | (32'h8 << i));
        smp(i == 0 ? 16'h03e8 : 16'h0000, 16'h0384, i == 1 ? 16'h03e8 : 16'h0000, 16'h0000,
            16'hc350, 16'hc350);
        chk(sys_ovr, 32'h1);
        chk(sys_release, 32'h1);
        av(1, 4'h0, 32'h1 | (32'h8 << ((i + 1) % 3)));
        smp(i == 0 ? 16'h03e8 : 16'h0000, 16'h0384, i == 1 ? 16'h03e8 : 16'h0000, 16'h0000,
            16'hc350, 16'hc350);
        chk(sys_ovr, 32'h0);
        chk(sys_release, 32'h0);
      end
      $display("test override done");
    end
  endtask
  task t_byp;
    begin
      av(1, 4'h0, 32'h1);
      smp(16'h03e8, 16'h0384, 16'h03e8, 16'h0000, 16'hc350, 16'hc350); chk(sys_release, 32'h0);
      @(posedge clk);
      sync_bypass_in <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk(sys_release, 32'h0);
      @(posedge clk);
      #1 chk(sys_release, 32'h1);
      av(1, 4'h0, 32'h0);
      repeat (3) @(posedge clk);
      #1 chk(sys_release, 32'h0);
      @(posedge clk);
      sync_bypass_in <= 1'b0;
      $display("test bypass done");
    end
  endtask
  task t_xfmr;
    begin
      av(1, 4'h5, 32'h0800);
      av(1, 4'h6, 32'h012c);
      av(1, 4'h0, 32'h5);
      smp(16'h03e8, 16'h0000, 16'h07d0, 16'h012c, 16'hc350, 16'hc350); chk(sys_sync, 32'h1);
      av(1, 4'h0, 32'h1);
      smp(16'h03e8, 16'h0000, 16'h07d0, 16'h012c, 16'hc350, 16'hc350); chk(sys_sync, 32'h0);
      av(1, 4'h6, 32'hfed4);
      av(1, 4'h0, 32'h5);
      smp(16'h03e8, 16'h0000, 16'h07d0, 16'h0ce4, 16'hc350, 16'hc350); chk(sys_sync, 32'h1);
      $display("test transformer done");
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_limits;
    t_lead;
    t_ovr;
    t_byp;
    t_xfmr;
    wrap_up;
  end
  // Watchdog
  initial begin
    #500000;
    err_count++;
    wrap_up;
  end
endmodule
